// ---- design/tpm_top.sv ----
`include "tpm_defines.svh"
`default_nettype none
module tpm_top #(
    parameter int NCH = `TPM_NCH
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins
    input  wire logic [NCH-1:0]    cap_in,
    output logic [NCH-1:0]         w_pwm_out,
    output logic                   ir_out,
    output logic [1:0]             n_pwm_out
);
    localparam int WB = `TPM_W_BITS;
    localparam int NB = `TPM_N_BITS;

    // Software registers
    logic [31:0]           w_ctrl_q, w_ctrl_d;
    logic [WB-1:0]         w_per_q, w_per_d;
    logic [NCH-1:0]        ch_mode_q, ch_mode_d;
    logic [WB-1:0]         ch_val_q [NCH];
    logic [WB-1:0]         ch_val_d [NCH];
    logic [31:0]           n_ctrl_q [2];
    logic [31:0]           n_ctrl_d [2];
    logic [2*NB-1:0]       n_cfg_q [2];
    logic [2*NB-1:0]       n_cfg_d [2];
    logic [2:0]            stat_q, stat_d;
    logic [NCH-1:0]        cap_flg_q, cap_flg_d;
    // Capture pipeline and outputs
    logic [NCH-1:0]        sync1_q, sync2_q, sync3_q;
    logic [NCH-1:0]        w_pwm_q, w_pwm_d;
    logic                  ir_q, ir_d;
    logic [1:0]            n_pwm_q, n_pwm_d;
    logic [31:0]           rdata_q, rdata_d;

    logic                  wr, rd;
    logic                  w_tick, w_wrap;
    logic [WB-1:0]         w_cnt;
    logic [1:0]            n_tick, n_wrap;
    logic [NB-1:0]         n_cnt [2];
    logic [NCH-1:0]        cap_edge;

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = rdata_q;

    // Wide timer, IR mode counts narrow-0 periods
    tpm_counter #(.W(WB)) u_wide (
        .clk          (clk),
        .rst          (rst),
        .en           (w_ctrl_q[`TPM_CTRL_EN]),
        .ext_tick_sel (w_ctrl_q[`TPM_CTRL_IR]),
        .ext_tick     (n_wrap[0]),
        .pre          (w_ctrl_q[`TPM_PRE_LSB +: `TPM_PRE_W]),
        .period       (w_per_q),
        .count        (w_cnt),
        .tick         (w_tick),
        .wrap         (w_wrap)
    );

    for (genvar n = 0; n < 2; n++) begin : g_narrow
        tpm_counter #(.W(NB)) u_nar (
            .clk          (clk),
            .rst          (rst),
            .en           (n_ctrl_q[n][`TPM_CTRL_EN]),
            .ext_tick_sel (1'b0),
            .ext_tick     (1'b0),
            .pre          (n_ctrl_q[n][`TPM_PRE_LSB +: `TPM_PRE_W]),
            .period       (n_cfg_q[n][NB-1:0]),
            .count        (n_cnt[n]),
            .tick         (n_tick[n]),
            .wrap         (n_wrap[n])
        );
    end

    // Edge detect reads only the second and third stages
    assign cap_edge = sync2_q ^ sync3_q;

    always_comb begin
        w_ctrl_d  = w_ctrl_q;
        w_per_d   = w_per_q;
        ch_mode_d = ch_mode_q;
        ch_val_d  = ch_val_q;
        n_ctrl_d  = n_ctrl_q;
        n_cfg_d   = n_cfg_q;
        stat_d    = stat_q;
        cap_flg_d = cap_flg_q;
        w_pwm_d   = w_pwm_q;
        n_pwm_d   = n_pwm_q;
        rdata_d   = rdata_q;
        // Software write, clear-on-write-one for flags
        if (wr) begin
            unique case (paddr)
                `TPM_A_W_CTRL:  w_ctrl_d  = pwdata;
                `TPM_A_W_PER:   w_per_d   = pwdata[WB-1:0];
                `TPM_A_CH_MODE: ch_mode_d = pwdata[NCH-1:0];
                `TPM_A_N0_CTRL: n_ctrl_d[0] = pwdata;
                `TPM_A_N0_CFG:  n_cfg_d[0]  = pwdata[2*NB-1:0];
                `TPM_A_N1_CTRL: n_ctrl_d[1] = pwdata;
                `TPM_A_N1_CFG:  n_cfg_d[1]  = pwdata[2*NB-1:0];
                `TPM_A_STAT:    stat_d    = stat_q & ~pwdata[2:0];
                `TPM_A_CAP_FLG: cap_flg_d = cap_flg_q & ~pwdata[NCH-1:0];
                default: ;
            endcase
            for (int i = 0; i < NCH; i++) begin
                if (paddr == `TPM_A_CH_BASE + 12'(4 * i)) begin
                    ch_val_d[i] = pwdata[WB-1:0];
                end
            end
        end
        // Period events, set wins over clear
        if (w_wrap)    stat_d[0] = 1'b1;
        if (n_wrap[0]) stat_d[1] = 1'b1;
        if (n_wrap[1]) stat_d[2] = 1'b1;
        // Wide channels
        for (int i = 0; i < NCH; i++) begin
            if (ch_mode_q[i] == tpm_pkg::TPM_CAPTURE) begin
                w_pwm_d[i] = 1'b0;
                if (cap_edge[i]) begin
                    ch_val_d[i]  = w_cnt;
                    cap_flg_d[i] = 1'b1;
                end
            end else begin
                w_pwm_d[i] = w_ctrl_q[`TPM_CTRL_EN]
                             && (w_cnt < ch_val_q[i]);
            end
        end
        // Narrow channels
        for (int n = 0; n < 2; n++) begin
            n_pwm_d[n] = n_ctrl_q[n][`TPM_CTRL_EN]
                && (n_cnt[n] < n_cfg_q[n][`TPM_N_CMP_LSB +: NB]);
        end
        // Read data captured in setup phase
        if (rd) begin
            rdata_d = '0;
            unique case (paddr)
                `TPM_A_W_CTRL:  rdata_d = w_ctrl_q;
                `TPM_A_W_PER:   rdata_d[WB-1:0] = w_per_q;
                `TPM_A_W_CNT:   rdata_d[WB-1:0] = w_cnt;
                `TPM_A_CH_MODE: rdata_d[NCH-1:0] = ch_mode_q;
                `TPM_A_N0_CTRL: rdata_d = n_ctrl_q[0];
                `TPM_A_N0_CFG:  rdata_d[2*NB-1:0] = n_cfg_q[0];
                `TPM_A_N1_CTRL: rdata_d = n_ctrl_q[1];
                `TPM_A_N1_CFG:  rdata_d[2*NB-1:0] = n_cfg_q[1];
                `TPM_A_STAT:    rdata_d[2:0] = stat_q;
                `TPM_A_CAP_FLG: rdata_d[NCH-1:0] = cap_flg_q;
                default: ;
            endcase
            for (int i = 0; i < NCH; i++) begin
                if (paddr == `TPM_A_CH_BASE + 12'(4 * i)) begin
                    rdata_d[WB-1:0] = ch_val_q[i];
                end
            end
        end
        // IR carrier gating
        ir_d = w_pwm_q[0] && n_pwm_q[0] && w_ctrl_q[`TPM_CTRL_IR];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_ctrl_q  <= '0;
            w_per_q   <= '1;
            ch_mode_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                ch_val_q[i] <= '0;
            end
            for (int n = 0; n < 2; n++) begin
                n_ctrl_q[n] <= '0;
                n_cfg_q[n]  <= {{NB{1'b0}}, {NB{1'b1}}};
            end
            stat_q    <= '0;
            cap_flg_q <= '0;
            sync1_q   <= '0;
            sync2_q   <= '0;
            sync3_q   <= '0;
            w_pwm_q   <= '0;
            ir_q      <= 1'b0;
            n_pwm_q   <= '0;
            rdata_q   <= '0;
        end else begin
            w_ctrl_q  <= w_ctrl_d;
            w_per_q   <= w_per_d;
            ch_mode_q <= ch_mode_d;
            ch_val_q  <= ch_val_d;
            n_ctrl_q  <= n_ctrl_d;
            n_cfg_q   <= n_cfg_d;
            stat_q    <= stat_d;
            cap_flg_q <= cap_flg_d;
            sync1_q   <= cap_in;
            sync2_q   <= sync1_q;
            sync3_q   <= sync2_q;
            w_pwm_q   <= w_pwm_d;
            ir_q      <= ir_d;
            n_pwm_q   <= n_pwm_d;
            rdata_q   <= rdata_d;
        end
    end

    assign w_pwm_out = w_pwm_q;
    assign n_pwm_out = n_pwm_q;
    assign ir_out    = ir_q;
endmodule
`default_nettype wire

// ---- common/tpm_defines.svh ----
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH
// Register byte addresses
`define TPM_A_W_CTRL   12'h000
`define TPM_A_W_PER    12'h004
`define TPM_A_W_CNT    12'h008
`define TPM_A_CH_MODE  12'h00c
`define TPM_A_CH_BASE  12'h010
`define TPM_A_N0_CTRL  12'h030
`define TPM_A_N0_CFG   12'h034
`define TPM_A_N1_CTRL  12'h038
`define TPM_A_N1_CFG   12'h03c
`define TPM_A_STAT     12'h040
`define TPM_A_CAP_FLG  12'h044
// Control fields
`define TPM_CTRL_EN    0
`define TPM_CTRL_IR    1
`define TPM_PRE_LSB    8
`define TPM_PRE_W      8
// Narrow config fields
`define TPM_N_CMP_LSB  8
// Widths
`define TPM_W_BITS     16
`define TPM_N_BITS     8
`define TPM_NCH        5
`endif

// ---- common/tpm_pkg.sv ----
`default_nettype none
package tpm_pkg;
    typedef enum logic {TPM_PWM, TPM_CAPTURE} tpm_chmode_e;
    typedef logic [7:0] tpm_pre_t;
endpackage
`default_nettype wire

// ---- design/tpm_counter.sv ----
`include "tpm_defines.svh"
`default_nettype none
module tpm_counter #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Control
    input  wire logic               en,
    input  wire logic               ext_tick_sel,
    input  wire logic               ext_tick,
    input  wire tpm_pkg::tpm_pre_t  pre,
    input  wire logic [W-1:0]       period,
    // State
    output logic [W-1:0]            count,
    output logic                    tick,
    output logic                    wrap
);
    tpm_pkg::tpm_pre_t pre_q, pre_d;
    logic [W-1:0]      cnt_q, cnt_d;
    logic              pre_tick;

    assign pre_tick = (pre_q == pre);
    assign tick     = en && (ext_tick_sel ? ext_tick : pre_tick);
    assign wrap     = tick && (cnt_q == period);
    assign count    = cnt_q;

    always_comb begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        if (!en) begin
            pre_d = '0;
        end else if (pre_tick) begin
            pre_d = '0; // Prescaler divides by pre+1
        end else begin
            pre_d = pre_q + 8'h01;
        end
        if (tick) begin
            if (cnt_q == period) begin
                cnt_d = '0; // Restart from zero at period
            end else begin
                cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q <= '0;
            cnt_q <= '0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tpm_monitor.sv ----
`default_nettype none
module tpm_monitor #(
    parameter int NCH = 5
) (
    // Clock and reset
    input wire logic           clk,
    input wire logic           rst,
    // APB
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [11:0]    paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    // Pins
    input wire logic [NCH-1:0] cap_in,
    input wire logic [NCH-1:0] w_pwm_out,
    input wire logic           ir_out,
    input wire logic [1:0]     n_pwm_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic        wr = psel && penable && pwrite;
    wire logic        rs = psel && !penable && !pwrite;
    wire logic        both = w_pwm_out[0] & n_pwm_out[0];
    wire logic [15:0] wlo = pwdata[15:0];
    logic             ir_q, ir_d, z_q, z_d, z2_q;
    // Track IR bit and narrow-0 compare of zero
    always_comb begin
        ir_d = ir_q;
        z_d = z_q;
        if (wr && paddr == 12'h000) ir_d = pwdata[1];
        if (wr && paddr == 12'h034) z_d = (pwdata[15:8] == 8'h00);
    end
    always_ff @(posedge clk) begin
        ir_q <= rst ? 1'b0 : ir_d;
        z_q <= rst ? 1'b1 : z_d;
        z2_q <= rst ? 1'b1 : z_q;
    end
    AST_READY: assert property (psel && penable |-> pready && !pslverr)
        else $error("access not ready or error flagged");
    AST_RESET_QUIET: assert property ($fell(rst) |->
        w_pwm_out == '0 && !ir_out && n_pwm_out == 2'h0 && prdata == 32'h0)
        else $error("outputs not idle after reset");
    AST_UNMAPPED: assert property (rs && paddr == 12'h0fc |=>
        prdata == 32'h0) else $error("unmapped read not zero");
    AST_PRDATA_HOLDS: assert property (!rs |=> $stable(prdata))
        else $error("read data changed without read");
    AST_READBACK: assert property ((wr && (paddr == 12'h004 ||
        paddr == 12'h034 || paddr[11:4] == 8'h01 || paddr == 12'h020))
        ##1 (rs && paddr == $past(paddr)) |=>
        prdata == {16'h0, $past(wlo, 2)}) else $error("readback differs");
    AST_IR_GATE: assert property (ir_out |-> both || $past(both))
        else $error("ir output without both sources high");
    AST_IR_OFF: assert property (!ir_q && !$past(ir_q) &&
        !$past(ir_q, 2) |-> !ir_out) else $error("ir output outside ir mode");
    AST_NPWM_ZERO: assert property (z_q && z2_q |-> !n_pwm_out[0])
        else $error("narrow pwm high with zero compare");
endmodule
bind tpm_top tpm_monitor #(.NCH(NCH)) i_tpm_monitor (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cap_in(cap_in), .w_pwm_out(w_pwm_out), .ir_out(ir_out),
    .n_pwm_out(n_pwm_out));
`default_nettype wire

// ---- tb/tpm_pins.sv ----
`default_nettype none
module tpm_pins (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Toggle requests and capture pins
    input wire logic [4:0] tog,
    output var logic [4:0] cap_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Levels change only on request, held many cycles
    always @(posedge clk)
        cap_in <= rst ? 5'h00 : cap_in ^ tog;
endmodule
`default_nettype wire

// ---- tb/test_timer_pwm_ir_modulator.sv ----
`default_nettype none
module test_timer_pwm_ir_modulator;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, ir_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  cap_in, w_pwm_out, tog;
    logic [1:0]  n_pwm_out;
    int          failures, checked, cyc, hw, hi, h0, h1;
    tpm_top i_tpm_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
        .w_pwm_out(w_pwm_out), .ir_out(ir_out), .n_pwm_out(n_pwm_out));
    tpm_pins i_tpm_pins (.clk(clk), .rst(rst), .tog(tog), .cap_in(cap_in));
    task automatic stop_test;
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic measure(input int n);
        hw = 0;
        hi = 0;
        h0 = 0;
        h1 = 0;
        repeat (20) @(posedge clk);
        repeat (n) begin
            @(posedge clk);
            hw += int'(w_pwm_out[1]);
            hi += int'(ir_out);
            h0 += int'(n_pwm_out[0]);
            h1 += int'(n_pwm_out[1]);
        end
    endtask
    task automatic t_reset;
        rdc(12'h004, 32'h0000ffff);
        rdc(12'h034, 32'h000000ff);
        rdc(12'h0fc, 32'h0);
        idle();
    endtask
    task automatic t_readback;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 12'h010 + 12'(4 * i), 32'h1230 + 32'(i));
            rdc(12'h010 + 12'(4 * i), 32'h1230 + 32'(i));
        end
        apb(1'b1, 12'h008, 32'habcd);
        rdc(12'h008, 32'h0);
        idle();
    endtask
    task automatic t_narrow;
        apb(1'b1, 12'h034, 32'h0203);
        apb(1'b1, 12'h03c, 32'h0101);
        apb(1'b1, 12'h030, 32'h0001);
        apb(1'b1, 12'h038, 32'h0101);
        idle();
        measure(40);
        chk(32'(h0), 32'd20);
        chk(32'(h1), 32'd20);
        rdc(12'h040, 32'h6);
        apb(1'b1, 12'h030, 32'h0);
        apb(1'b1, 12'h038, 32'h0);
        apb(1'b1, 12'h040, 32'h6);
        rdc(12'h040, 32'h0);
        idle();
    endtask
    task automatic t_ir;
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h030, 32'h1);
        apb(1'b1, 12'h000, 32'h3);
        idle();
        measure(80);
        chk(32'(hi), 32'd20);
        apb(1'b1, 12'h034, 32'h0003);
        idle();
        measure(8);
        chk(32'(h0), 32'd0);
        chk(32'(hi), 32'd0);
    endtask
    task automatic t_wide;
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h030, 32'h0);
        apb(1'b1, 12'h040, 32'h7);
        apb(1'b1, 12'h004, 32'h9);
        apb(1'b1, 12'h014, 32'h3);
        apb(1'b1, 12'h000, 32'h1);
        idle();
        measure(50);
        chk(32'(hw), 32'd15);
        chk(32'(hi), 32'd0);
        rdc(12'h040, 32'h1);
        idle();
    endtask
    task automatic t_capture;
        apb(1'b1, 12'h00c, 32'h4);
        apb(1'b1, 12'h044, 32'h1f);
        idle();
        tog <= 5'h04;
        @(posedge clk);
        tog <= 5'h00;
        repeat (10) @(posedge clk);
        rdc(12'h044, 32'h4);
        apb(1'b0, 12'h018, 32'h0);
        chk(32'(rd <= 32'd9), 32'h1);
        apb(1'b1, 12'h044, 32'h4);
        rdc(12'h044, 32'h0);
        idle();
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, tog} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_readback();
        t_narrow();
        t_ir();
        t_wide();
        t_capture();
        stop_test();
    end
endmodule
`default_nettype wire
